// File: pkg/lcd_port_pkg.sv
// constants for the lcd host port: pin decode, commands, apb map, reset values
// assumes a single 40 MHz pclk domain and pins synchronous to it
// How it works
// - all traffic uses an 8-bit data bus; device drives it only during reads
// - select/direction decode: 11 data read, 10 data write, 01 status, 00 command
// - while busy, every access except status read is ignored; a data read still gets ram data on the bus, with no column step
// - status read shows the busy flag on data bit seven
// - start line register, set by command, picks the line on the first row
// - 7-bit presettable column counter addresses ram, set by column command
// - column counter advances by one after each display data read or write
// - column counter stops at 50H and never increments past it
// - display ram holds one bit per pixel
// - 2-bit page register, set by page command, addresses ram pages
package lcd_port_pkg;

  localparam int   CLK_PERIOD_NS = 25;
  // host system cycle time, 5 V figure
  localparam int   T_CYC_NS      = 1000;
  localparam int   T_CYC_CYCLES  = (T_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int   DATA_W        = 8;
  localparam int   COL_W         = 7;
  localparam int   PAGE_W        = 2;
  localparam int   LINE_W        = 5;
  localparam int   RAM_AW        = PAGE_W + COL_W;
  localparam int   FIFO_DEPTH    = 16;
  localparam int   FIFO_W        = RAM_AW + DATA_W;

  localparam logic [COL_W-1:0] COL_LAST = 7'h50;
  localparam int   STATUS_BUSY_BIT = 7;

  // command encodings: opcode field under mask equals match
  localparam logic [7:0] CMD_COL_MASK   = 8'h80;
  localparam logic [7:0] CMD_COL_MATCH  = 8'h00;
  localparam logic [7:0] CMD_PAGE_MASK  = 8'hFC;
  localparam logic [7:0] CMD_PAGE_MATCH = 8'hB8;
  localparam logic [7:0] CMD_LINE_MASK  = 8'hE0;
  localparam logic [7:0] CMD_LINE_MATCH = 8'hC0;

  // apb map
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam int   CTRL_HOLD_BIT    = 0;
  localparam int   CTRL_BUSY_LSB    = 8;
  localparam int   BUSY_CNT_W       = 8;
  localparam logic [BUSY_CNT_W-1:0] BUSY_CYCLES_RST = 8'(T_CYC_CYCLES / 4);
  localparam int   ST_BUSY_BIT      = 0;
  localparam int   ST_EMPTY_BIT     = 1;
  localparam int   ST_COL_LSB       = 8;
  localparam int   ST_PAGE_LSB      = 16;
  localparam int   ST_LINE_LSB      = 24;

  typedef enum logic [1:0] {
    OP_CMD_WRITE  = 2'b00,
    OP_STAT_READ  = 2'b01,
    OP_DATA_WRITE = 2'b10,
    OP_DATA_READ  = 2'b11
  } host_op_t;

endpackage

// File: sim/lcd_host_model.sv
// 68-style host processor driving the lcd port pins
// assumes pclk from the bench; device drives the bus while data_oe_n is low
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model
  import lcd_port_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe_n,
  output logic                   cs_n = 1'b1,
  output logic                   cmd_data_select = 1'b0,
  output logic                   read_not_write = 1'b1,
  output logic                   enable_strobe = 1'b0,
  output logic      [DATA_W-1:0] data_in
);
  logic              drv = 1'b0;
  logic [DATA_W-1:0] wd = 8'h00;
  logic [DATA_W-1:0] idle = 8'h5A;
  // floating bus shows a moving pattern
  always @(posedge pclk) idle <= ~idle;
  assign data_in = !data_oe_n ? data_out : (drv ? wd : idle);
  task automatic access(input logic cs, sel, rw, input logic [DATA_W-1:0] d, input int gap,
                        output logic [DATA_W-1:0] rd);
    @(posedge pclk);
    cs_n <= ~cs;
    cmd_data_select <= sel;
    read_not_write <= rw;
    drv <= ~rw;
    wd <= d;
    @(posedge pclk);
    enable_strobe <= 1'b1;
    repeat (3) @(posedge pclk);
    rd = data_in;
    // falls with select still held
    enable_strobe <= 1'b0;
    @(posedge pclk);
    cs_n <= 1'b1;
    drv <= 1'b0;
    repeat (gap) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: sim/lcd_host_port_chk.sv
// assertions on the lcd host port pins and apb slave
// assumes one pclk domain; bound to lcd_host_port from the bench
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port_chk
  import lcd_port_pkg::*;
#(
  parameter int FIFO_DEPTH_P = 16
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              ce,
  input wire logic              cs_n,
  input wire logic              cmd_data_select,
  input wire logic              read_not_write,
  input wire logic              enable_strobe,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic              data_oe_n,
  input wire logic [LINE_W-1:0] first_common_row,
  input wire logic              busy_flag,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic e_q;
  logic rd_on;
  logic cmd_on;
  logic map_ok;
  assign rd_on  = enable_strobe & ~cs_n & read_not_write;
  assign cmd_on = enable_strobe & ~cs_n & ~cmd_data_select & ~read_not_write;
  assign map_ok = (paddr == REG_CTRL_OFS) | (paddr == REG_STATUS_OFS);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_q <= 1'b0;
    end else begin
      e_q <= enable_strobe;
    end
  end
  property p_oe; data_oe_n == !$past(rd_on); endproperty
  property p_stat; rd_on && !e_q && !cmd_data_select |=> data_out == {busy_flag, 7'h00}; endproperty
  property p_busy; $past(cmd_on) && !enable_strobe && !busy_flag |-> ##[1:2] busy_flag; endproperty
  // copy moves two edges after the strobe fall that ends the command
  property p_row; $changed(first_common_row) |-> $past(cmd_on, 3) && !$past(enable_strobe, 2); endproperty
  property p_rdy; psel && !penable |=> pready; endproperty
  property p_one; pready |-> psel && penable ##1 !pready; endproperty
  property p_unmap; pready && !map_ok |-> pslverr && prdata == 32'h00000000; endproperty
  property p_map; pready && map_ok |-> !pslverr; endproperty
  a_oe: assert property (p_oe) else $error("bus drive outside read");
  a_stat: assert property (p_stat) else $error("status byte wrong");
  a_busy: assert property (p_busy) else $error("command did not set busy");
  a_row: assert property (p_row) else $error("start line moved alone");
  a_rdy: assert property (p_rdy) else $error("apb ready late");
  a_one: assert property (p_one) else $error("apb ready misplaced");
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  a_map: assert property (p_map) else $error("mapped gave error");
  c_stat: cover property (rd_on && !e_q && !cmd_data_select && busy_flag);
  c_cmd: cover property ($past(cmd_on) && !enable_strobe);
  c_err: cover property (pready && pslverr);
endmodule
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for lcd_host_port with host model and apb master
// assumes the checker and host model files are compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench
  import lcd_port_pkg::*;
;
  localparam logic [2:0] CMD = 3'b100, STR = 3'b101, DWR = 3'b110, DRD = 3'b111;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              cs_n, cmd_data_select, read_not_write, enable_strobe, data_oe_n;
  logic              busy_flag, pready, pslverr, err;
  logic [DATA_W-1:0] data_in, data_out, hb;
  logic [LINE_W-1:0] first_common_row;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h00000000, prdata, rv;
  int                n_mismatch = 0, n_checks = 0;
  always #12.5 pclk = ~pclk;
  lcd_host_port #(.FIFO_DEPTH_P(2)) uut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .cs_n(cs_n), .cmd_data_select(cmd_data_select), .read_not_write(read_not_write),
    .enable_strobe(enable_strobe), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .first_common_row(first_common_row), .busy_flag(busy_flag),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  lcd_host_model host_bus (.pclk(pclk), .data_out(data_out), .data_oe_n(data_oe_n),
    .cs_n(cs_n), .cmd_data_select(cmd_data_select), .read_not_write(read_not_write),
    .enable_strobe(enable_strobe), .data_in(data_in));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("BAD t=%0t apb wait ran out", $time);
      complete_run();
    end else begin
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic host(input logic [2:0] m, input logic [7:0] d, input int gap);
    host_bus.access(m[2], m[1], m[0], d, gap, hb);
  endtask
  task automatic t_reset();
    check(32'(data_oe_n), 32'h00000001);
    check(32'(first_common_row), 32'h00000000);
    apb(1'b0, REG_CTRL_OFS, 32'h00000000);
    check(rv, 32'h00000A00);
    apb(1'b0, 8'h08, 32'h00000000);
    check({err, rv[30:0]}, 32'h80000000);
    apb(1'b1, REG_STATUS_OFS, 32'hFFFFFFFF);
    apb(1'b0, REG_STATUS_OFS, 32'h00000000);
    check({err, rv[30:0]}, 32'h00000002);
  endtask
  task automatic t_cmds();
    host(CMD, 8'h4E, 40);
    host(CMD, 8'hBA, 40);
    host(CMD, 8'hD3, 40);
    check(32'(first_common_row), 32'h00000013);
    host(STR, 8'h00, 40);
    check(32'(hb), 32'h00000000);
    for (int i = 0; i < 4; i++) host(DWR, 8'hA1 + 8'(i), 40);
    apb(1'b0, REG_STATUS_OFS, 32'h00000000);
    check(rv, 32'h13025002);
    host(CMD, 8'h4E, 40);
    for (int i = 0; i < 3; i++) begin
      host(DRD, 8'h00, 40);
      check(32'(hb), 32'(i == 2 ? 8'hA4 : 8'hA1 + 8'(i)));
    end
  endtask
  task automatic t_busy();
    host(CMD, 8'h10, 0);
    host(STR, 8'h00, 40);
    check(32'(hb), 32'h00000080);
    host(CMD, 8'h20, 0);
    host(CMD, 8'h30, 40);
    host(3'b000, 8'h40, 40);
    apb(1'b0, REG_STATUS_OFS, 32'h00000000);
    check(rv, 32'h13022002);
  endtask
  task automatic t_fifo();
    // known byte where the refused write would land; ram is not reset
    host(CMD, 8'h32, 40);
    host(DWR, 8'h5C, 40);
    apb(1'b1, REG_CTRL_OFS, 32'h00000A01);
    host(CMD, 8'h30, 40);
    for (int i = 0; i < 3; i++) host(DWR, 8'hC0 + 8'(i), 2);
    check(32'(busy_flag), 32'h00000001);
    apb(1'b0, REG_STATUS_OFS, 32'h00000000);
    check(rv, 32'h13023201);
    apb(1'b1, REG_CTRL_OFS, 32'h00000A00);
    repeat (8) @(posedge pclk);
    apb(1'b0, REG_STATUS_OFS, 32'h00000000);
    check(rv, 32'h13023202);
    host(CMD, 8'h30, 40);
    for (int i = 0; i < 3; i++) begin
      host(DRD, 8'h00, 40);
      check(32'(hb), 32'(i == 2 ? 8'h5C : 8'hC0 + 8'(i)));
    end
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cmds();
    t_busy();
    t_fifo();
    complete_run();
  end
endmodule
bind lcd_host_port lcd_host_port_chk #(.FIFO_DEPTH_P(FIFO_DEPTH_P)) chk (.pclk(pclk),
  .presetn(presetn), .ce(ce), .cs_n(cs_n), .cmd_data_select(cmd_data_select),
  .read_not_write(read_not_write), .enable_strobe(enable_strobe), .data_in(data_in),
  .data_out(data_out), .data_oe_n(data_oe_n), .first_common_row(first_common_row),
  .busy_flag(busy_flag), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// File: src/lcd_host_port.sv
// lcd controller host port: 68-style strobe decode, status, column/page/line
// registers, display ram with write fifo, apb control and status
// assumes pins synchronous to pclk; host keeps each pin stable while enable is high
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port
  import lcd_port_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  // host pins
  input  wire logic              cs_n,
  input  wire logic              cmd_data_select,
  input  wire logic              read_not_write,
  input  wire logic              enable_strobe,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe_n,
  // display side
  output logic      [LINE_W-1:0] first_common_row,
  output logic                   busy_flag,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr
);

  // captured access fields, held from the last cycle the strobe was high
  logic              e_q;
  logic              acc_cs_n_reg;
  logic              acc_sel_reg;
  logic              acc_rw_reg;
  logic [DATA_W-1:0] acc_data_reg;
  logic              strobe_fall;
  logic              strobe_rise;
  host_op_t          acc_op;

  logic [COL_W-1:0]      col_reg;
  logic [PAGE_W-1:0]     page_reg;
  logic [LINE_W-1:0]     start_line_reg;
  logic [BUSY_CNT_W-1:0] exec_cnt_reg;
  logic [BUSY_CNT_W-1:0] busy_cycles_reg;
  logic                  drain_hold_reg;
  logic                  busy;

  logic [DATA_W-1:0] ram [0:(1<<RAM_AW)-1];
  logic [DATA_W-1:0] ram_rd_reg;

  logic              fifo_in_valid;
  logic              fifo_in_ready;
  logic [FIFO_W-1:0] fifo_in_data;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [FIFO_W-1:0] fifo_out_data;

  logic              accept;
  logic              do_col_step;

  assign strobe_fall = e_q & ~enable_strobe;
  assign strobe_rise = ~e_q & enable_strobe;
  assign acc_op      = host_op_t'({acc_sel_reg, acc_rw_reg});

  // busy while a command executes or the write fifo cannot take data
  assign busy = (exec_cnt_reg != '0) | ~fifo_in_ready;

  // completed access with select active and device free
  assign accept = strobe_fall & ~acc_cs_n_reg & ~busy;

  assign do_col_step = accept &
                       ((acc_op == OP_DATA_WRITE) | (acc_op == OP_DATA_READ));

  assign fifo_in_valid  = accept & (acc_op == OP_DATA_WRITE);
  assign fifo_in_data   = {page_reg, col_reg, acc_data_reg};
  assign fifo_out_ready = ~drain_hold_reg;

  // ---------------------------------------------------------------
  // pin capture
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_q          <= 1'b0;
      acc_cs_n_reg <= 1'b1;
      acc_sel_reg  <= 1'b0;
      acc_rw_reg   <= 1'b0;
      acc_data_reg <= '0;
    end else if (ce) begin
      e_q <= enable_strobe;
      if (enable_strobe) begin
        acc_cs_n_reg <= cs_n;
        acc_sel_reg  <= cmd_data_select;
        acc_rw_reg   <= read_not_write;
        acc_data_reg <= data_in;
      end
    end
  end

  // ---------------------------------------------------------------
  // read data drive: bus driven one pclk behind a selected read strobe being high
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe_n <= 1'b1;
    end else if (ce) begin
      data_oe_n <= ~(enable_strobe & ~cs_n & read_not_write);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= '0;
    end else if (ce && strobe_rise && !cs_n && read_not_write) begin
      if (cmd_data_select) begin
        data_out <= ram_rd_reg;
      end else begin
        data_out                  <= '0;
        data_out[STATUS_BUSY_BIT] <= busy;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_flag <= 1'b0;
    end else if (ce) begin
      busy_flag <= busy;
    end
  end

  // ---------------------------------------------------------------
  // command execution timer; default ends well inside one system cycle
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_cnt_reg <= '0;
    end else if (ce) begin
      if (accept && acc_op == OP_CMD_WRITE) begin
        exec_cnt_reg <= busy_cycles_reg;
      end else if (exec_cnt_reg != '0) begin
        exec_cnt_reg <= exec_cnt_reg - 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // column address counter
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_reg <= '0;
    end else if (ce) begin
      if (accept && acc_op == OP_CMD_WRITE &&
          (acc_data_reg & CMD_COL_MASK) == CMD_COL_MATCH) begin
        col_reg <= acc_data_reg[COL_W-1:0];
      end else if (do_col_step && col_reg < COL_LAST) begin
        col_reg <= col_reg + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // page register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_reg <= '0;
    end else if (ce && accept && acc_op == OP_CMD_WRITE &&
                 (acc_data_reg & CMD_PAGE_MASK) == CMD_PAGE_MATCH) begin
      page_reg <= acc_data_reg[PAGE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // display start line
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_line_reg <= '0;
    end else if (ce && accept && acc_op == OP_CMD_WRITE &&
                 (acc_data_reg & CMD_LINE_MASK) == CMD_LINE_MATCH) begin
      start_line_reg <= acc_data_reg[LINE_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_common_row <= '0;
    end else if (ce) begin
      first_common_row <= start_line_reg;
    end
  end

  // ---------------------------------------------------------------
  // write fifo between the host port and the display ram
  // ---------------------------------------------------------------
  lcd_word_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_wr_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------
  // display ram: each byte is eight vertical pixels, one bit each
  // ---------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (ce && fifo_out_valid && fifo_out_ready) begin
      ram[fifo_out_data[FIFO_W-1:DATA_W]] <= fifo_out_data[DATA_W-1:0];
    end
  end

  // read port follows the current page and column
  always_ff @(posedge pclk) begin
    if (ce) begin
      ram_rd_reg <= ram[{page_reg, col_reg}];
    end
  end

  // ---------------------------------------------------------------
  // apb slave: no wait states, pready in the first access cycle, registered answer
  // ---------------------------------------------------------------
  logic apb_setup;
  logic hit_ctrl;
  logic hit_status;

  assign apb_setup  = psel & ~penable & ~pready;
  assign hit_ctrl   = (paddr == REG_CTRL_OFS);
  assign hit_status = (paddr == REG_STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else if (ce) begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~hit_ctrl & ~hit_status;
      prdata  <= '0;
      if (apb_setup && !pwrite) begin
        if (hit_ctrl) begin
          prdata[CTRL_HOLD_BIT]                        <= drain_hold_reg;
          prdata[CTRL_BUSY_LSB +: BUSY_CNT_W]          <= busy_cycles_reg;
        end else if (hit_status) begin
          prdata[ST_BUSY_BIT]                          <= busy;
          prdata[ST_EMPTY_BIT]                         <= ~fifo_out_valid;
          prdata[ST_COL_LSB +: COL_W]                  <= col_reg;
          prdata[ST_PAGE_LSB +: PAGE_W]                <= page_reg;
          prdata[ST_LINE_LSB +: LINE_W]                <= start_line_reg;
        end
      end
    end
  end

  // control takes effect at the access edge that ends the transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drain_hold_reg  <= 1'b0;
      busy_cycles_reg <= BUSY_CYCLES_RST;
    end else if (ce && psel && penable && pready && pwrite && hit_ctrl) begin
      drain_hold_reg  <= pwdata[CTRL_HOLD_BIT];
      busy_cycles_reg <= pwdata[CTRL_BUSY_LSB +: BUSY_CNT_W];
    end
  end

endmodule
`default_nettype wire

// File: src/lcd_word_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, async active-low reset, clock enable freezing state
`timescale 1ns/10ps
`default_nettype none
module lcd_word_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge pclk) begin
    if (ce && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
